// [logic/tmx_edge_detect.sv]
/*
  Pin synchroniser and edge detector for one capture or count input.
  Assumes the pin is asynchronous to hclk; the event pulse is one cycle.
*/
`default_nettype none

module tmx_edge_detect
  import tmx_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rise_sel,
  input  wire logic both_sel,
  // Event
  output var  logic evt
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic evt;
  } tmx_edge_t;

  tmx_edge_t r_q;
  tmx_edge_t r_d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_d      = r_q;
    r_d.meta = pin;
    r_d.sync = r_q.meta;
    r_d.prev = r_q.sync;
    if (both_sel) begin
      r_d.evt = r_q.sync ^ r_q.prev;
    end else if (rise_sel) begin
      r_d.evt = r_q.sync & ~r_q.prev;
    end else begin
      r_d.evt = ~r_q.sync & r_q.prev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign evt = r_q.evt;

endmodule : tmx_edge_detect

`default_nettype wire

// [logic/tmx_pkg.sv]
/*
  Constants shared by the timer event block: register map, field positions,
  reset values and prescaler masks.
  Assumes a single AHB-Lite slave decode on the low address byte.
*/
`default_nettype none

package tmx_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONTROL      = 8'h08;
  localparam logic [7:0] OFS_COUNTER      = 8'h0c;
  localparam logic [7:0] OFS_COMPARE_A    = 8'h10;
  localparam logic [7:0] OFS_COMPARE_B    = 8'h14;
  localparam logic [7:0] OFS_CAPTURE_A    = 8'h18;
  localparam logic [7:0] OFS_CAPTURE_B    = 8'h1c;
  localparam logic [7:0] OFS_CAPTURE_C    = 8'h20;
  localparam logic [7:0] OFS_CAPTURE_D    = 8'h24;

  // ----------------------------------------------------------------------
  // Enable and status bit positions (same position in both registers)
  // ----------------------------------------------------------------------
  localparam int BIT_CAP_A     = 7;
  localparam int BIT_CAP_B     = 6;
  localparam int BIT_CAP_C     = 5;
  localparam int BIT_CAP_D     = 4;
  localparam int BIT_CMP_A     = 3;
  localparam int BIT_CMP_B     = 2;
  localparam int BIT_WRAP      = 1;
  localparam int BIT_CLEAR_CMP = 0;
  localparam int BIT_EN_FIXED  = 0;

  // Event flags in the status register, bits 7..1
  localparam logic [7:0] FLAG_MASK = 8'hfe;

  // ----------------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------------
  localparam int BIT_EDGE_A = 7;
  localparam int BIT_EDGE_B = 6;
  localparam int BIT_EDGE_C = 5;
  localparam int BIT_EDGE_D = 4;
  localparam int BIT_BUF_A  = 3;
  localparam int BIT_BUF_B  = 2;
  localparam int CKS_HI     = 1;
  localparam int CKS_LO     = 0;

  localparam logic [1:0] CKS_DIV2 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV32 = 2'h2;
  localparam logic [1:0] CKS_EXT  = 2'h3;

  // ----------------------------------------------------------------------
  // Prescaler masks: tick when all masked bits are ones
  // ----------------------------------------------------------------------
  localparam logic [4:0] PRESC_MASK_2  = 5'h01;
  localparam logic [4:0] PRESC_MASK_8  = 5'h07;
  localparam logic [4:0] PRESC_MASK_32 = 5'h1f;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IRQ_ENABLE_RST = 8'h01;
  localparam logic [7:0]  STATUS_RST     = 8'h00;
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [15:0] COUNTER_RST    = 16'h0000;
  localparam logic [15:0] COUNTER_MAX    = 16'hffff;
  localparam logic [15:0] COMPARE_RST    = 16'hffff;
  localparam logic [15:0] CAPTURE_RST    = 16'h0000;

endpackage : tmx_pkg

`default_nettype wire

// [logic/tmx_timer_events.sv]
/*
  Free-running timer event block: interrupt enables, sticky event flags,
  capture A..D with optional buffering, compare A/B and counter wrap,
  reached over AHB-Lite.
  Assumes one AHB-Lite master, word transfers, and asynchronous pins.
*/
// Added by the designer: the register addresses and register access over AHB-Lite.
// Overview of operation
// - Enable bit 7 gates capture-A request; resets to 0.
// - Enable bit 6 gates capture-B request; resets to 0.
// - Enable bit 5 gates capture-C request; resets to 0.
// - Enable bit 4 gates capture-D request; resets to 0.
// - Enable bit 3 gates compare-A request; resets to 0.
// - Enable bit 2 gates compare-B request; resets to 0.
// - Enable bit 1 gates counter wrap request; resets to 0.
// - Enable bit 0 always reads one, writes ignored.
// - Status bits 7..1 only clear by written zero; bit 0 plain.
// - Status clears on reset and on low-power entry.
// - Capture A loads counter, sets flag; buffered moves old A into C.
// - Capture B loads counter, sets flag; buffered moves old B into D.
// - Unbuffered, C and D events load their registers and set flags.
// - Buffered A: C event still sets flag without loading C.
// - Buffered B: D event still sets flag without loading D.
// - Compare-A flag sets when counter equals compare A.
// - Compare-B flag sets when counter equals compare B.
// - Flags set by hardware only; clear needs read-as-one then write zero.
// - Wrap flag sets when counter goes from maximum to zero.
// - Status bit 0 clears counter on compare-A match.
// - Buffer enables make C and D buffer stages of A and B.
`default_nettype none

module tmx_timer_events
  import tmx_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Timer pins and power control
  input  wire logic [3:0]  capture_pin,
  input  wire logic        ext_count_pin,
  input  wire logic        low_power_entry,
  // Interrupt requests
  output var  logic        cap_a_irq,
  output var  logic        cap_b_irq,
  output var  logic        cap_c_irq,
  output var  logic        cap_d_irq,
  output var  logic        cmp_a_irq,
  output var  logic        cmp_b_irq,
  output var  logic        wrap_irq
);

  typedef struct packed {
    logic [7:0]  timer_irq_enable;
    logic [7:0]  timer_event_status;
    logic [7:0]  read_armed;
    logic [7:0]  timer_control;
    logic [15:0] free_running_counter;
    logic [15:0] compare_reg_a;
    logic [15:0] compare_reg_b;
    logic [15:0] capture_reg_a;
    logic [15:0] capture_reg_b;
    logic [15:0] capture_reg_c;
    logic [15:0] capture_reg_d;
    logic [4:0]  presc;
    logic        pend;
    logic        pend_wr;
    logic [7:0]  pend_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [7:1]  irq;
    logic [3:0]  warm;
  } tmx_regs_t;

  tmx_regs_t r_q;
  tmx_regs_t r_d;

  logic [3:0] cap_evt;
  logic       ext_evt;
  logic [3:0] cap_both;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic f_tick(input logic [4:0] presc, input logic [4:0] mask);
    f_tick = ((presc & mask) == mask);
  endfunction : f_tick

  function automatic logic f_both(input logic buf_en, input logic sel_p, input logic sel_s);
    f_both = buf_en & (sel_p != sel_s);
  endfunction : f_both

  function automatic logic [31:0] f_read(input tmx_regs_t r, input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      OFS_IRQ_ENABLE: begin
        v[7:0] = r.timer_irq_enable;
        v[BIT_EN_FIXED] = 1'b1;
      end
      OFS_EVENT_STATUS: v[7:0]  = r.timer_event_status;
      OFS_CONTROL:      v[7:0]  = r.timer_control;
      OFS_COUNTER:      v[15:0] = r.free_running_counter;
      OFS_COMPARE_A:    v[15:0] = r.compare_reg_a;
      OFS_COMPARE_B:    v[15:0] = r.compare_reg_b;
      OFS_CAPTURE_A:    v[15:0] = r.capture_reg_a;
      OFS_CAPTURE_B:    v[15:0] = r.capture_reg_b;
      OFS_CAPTURE_C:    v[15:0] = r.capture_reg_c;
      OFS_CAPTURE_D:    v[15:0] = r.capture_reg_d;
      default:          v       = 32'h0000_0000;
    endcase
    f_read = v;
  endfunction : f_read

  // ----------------------------------------------------------------------
  // Input pins
  // ----------------------------------------------------------------------
  // Buffered capture A/B takes both edges when the two edge selects differ
  assign cap_both[0] = f_both(r_q.timer_control[BIT_BUF_A], r_q.timer_control[BIT_EDGE_A],
                              r_q.timer_control[BIT_EDGE_C]);
  assign cap_both[1] = f_both(r_q.timer_control[BIT_BUF_B], r_q.timer_control[BIT_EDGE_B],
                              r_q.timer_control[BIT_EDGE_D]);
  assign cap_both[2] = 1'b0;
  assign cap_both[3] = 1'b0;

  for (genvar i = 0; i < 4; i++) begin : g_cap
    tmx_edge_detect u_cap (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (capture_pin[i]),
      .rise_sel (r_q.timer_control[BIT_EDGE_A - i]),
      .both_sel (cap_both[i]),
      .evt      (cap_evt[i])
    );
  end

  tmx_edge_detect u_ext (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin      (ext_count_pin),
    .rise_sel (1'b1),
    .both_sel (1'b0),
    .evt      (ext_evt)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        at_a;
    logic        at_b;
    logic        buf_a;
    logic        buf_b;
    logic [7:0]  set;
    logic [7:0]  clr;
    logic [31:0] wd;
    logic [3:0]  cap;
    logic        ext;
    tick  = 1'b0;
    at_a  = 1'b0;
    at_b  = 1'b0;
    buf_a = r_q.timer_control[BIT_BUF_A];
    buf_b = r_q.timer_control[BIT_BUF_B];
    set   = 8'h00;
    clr   = 8'h00;
    wd    = hwdata;
    cap   = cap_evt & {4{r_q.warm[3]}};
    ext   = ext_evt & r_q.warm[3];
    r_d   = r_q;

    // Pin events ignored until the synchronisers hold real pin levels
    r_d.warm = {r_q.warm[2:0], 1'b1};

    // Prescaler and count source
    r_d.presc = r_q.presc + 5'h01;
    unique case (r_q.timer_control[CKS_HI:CKS_LO])
      CKS_DIV2:  tick = f_tick(r_q.presc, PRESC_MASK_2);
      CKS_DIV8:  tick = f_tick(r_q.presc, PRESC_MASK_8);
      CKS_DIV32: tick = f_tick(r_q.presc, PRESC_MASK_32);
      CKS_EXT:   tick = ext;
    endcase

    // Counter, compare and wrap
    at_a = (r_q.free_running_counter == r_q.compare_reg_a);
    at_b = (r_q.free_running_counter == r_q.compare_reg_b);
    if (tick) begin
      set[BIT_CMP_A] = at_a;
      set[BIT_CMP_B] = at_b;
      set[BIT_WRAP]  = (r_q.free_running_counter == COUNTER_MAX);
      if (r_q.timer_event_status[BIT_CLEAR_CMP] && at_a) begin
        r_d.free_running_counter = COUNTER_RST;
      end else begin
        r_d.free_running_counter = r_q.free_running_counter + 16'h0001;
      end
    end

    // Captures C and D: own load only when not a buffer stage
    if (cap[2]) begin
      set[BIT_CAP_C] = 1'b1;
      if (!buf_a) begin
        r_d.capture_reg_c = r_q.free_running_counter;
      end
    end
    if (cap[3]) begin
      set[BIT_CAP_D] = 1'b1;
      if (!buf_b) begin
        r_d.capture_reg_d = r_q.free_running_counter;
      end
    end

    // Captures A and B with buffer shift
    if (cap[0]) begin
      set[BIT_CAP_A] = 1'b1;
      r_d.capture_reg_a = r_q.free_running_counter;
      if (buf_a) begin
        r_d.capture_reg_c = r_q.capture_reg_a;
      end
    end
    if (cap[1]) begin
      set[BIT_CAP_B] = 1'b1;
      r_d.capture_reg_b = r_q.free_running_counter;
      if (buf_b) begin
        r_d.capture_reg_d = r_q.capture_reg_b;
      end
    end

    // Bus data phase: one wait state, then write or read
    r_d.err = 1'b0;
    if (r_q.pend) begin
      r_d.pend  = 1'b0;
      r_d.ready = 1'b1;
      if (r_q.pend_wr) begin
        unique case (r_q.pend_addr)
          OFS_IRQ_ENABLE: begin
            r_d.timer_irq_enable = {wd[7:1], 1'b1};
          end
          OFS_EVENT_STATUS: begin
            // Only flags seen as one by an earlier read may clear
            clr = r_q.read_armed & ~wd[7:0] & FLAG_MASK;
            r_d.timer_event_status = (r_q.timer_event_status & ~clr & FLAG_MASK) |
                                     {7'h00, wd[BIT_CLEAR_CMP]};
            r_d.read_armed = r_q.read_armed & ~clr;
          end
          OFS_CONTROL:   r_d.timer_control        = wd[7:0];
          OFS_COUNTER:   r_d.free_running_counter = wd[15:0];
          OFS_COMPARE_A: r_d.compare_reg_a        = wd[15:0];
          OFS_COMPARE_B: r_d.compare_reg_b        = wd[15:0];
          default: begin
          end
        endcase
      end else begin
        r_d.rdata = f_read(r_q, r_q.pend_addr);
        if (r_q.pend_addr == OFS_EVENT_STATUS) begin
          r_d.read_armed = r_q.read_armed | (r_q.timer_event_status & FLAG_MASK);
        end
      end
    end

    // Bus address phase
    if (hsel && hready && htrans[1]) begin
      r_d.pend      = 1'b1;
      r_d.pend_wr   = hwrite;
      r_d.pend_addr = haddr[7:0];
      r_d.ready     = 1'b0;
    end

    // Hardware set after the bus write so it wins over a software clear
    r_d.timer_event_status = r_d.timer_event_status | set;

    // Low-power entry restores timer state
    if (low_power_entry) begin
      r_d.timer_irq_enable     = IRQ_ENABLE_RST;
      r_d.timer_event_status   = STATUS_RST;
      r_d.read_armed           = 8'h00;
      r_d.timer_control        = CONTROL_RST;
      r_d.free_running_counter = COUNTER_RST;
      r_d.compare_reg_a        = COMPARE_RST;
      r_d.compare_reg_b        = COMPARE_RST;
      r_d.capture_reg_a        = CAPTURE_RST;
      r_d.capture_reg_b        = CAPTURE_RST;
      r_d.capture_reg_c        = CAPTURE_RST;
      r_d.capture_reg_d        = CAPTURE_RST;
    end

    // Requests follow flag and enable of the next state
    r_d.irq = r_d.timer_event_status[7:1] & r_d.timer_irq_enable[7:1];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q                      <= '0;
      r_q.timer_irq_enable     <= IRQ_ENABLE_RST;
      r_q.timer_event_status   <= STATUS_RST;
      r_q.timer_control        <= CONTROL_RST;
      r_q.free_running_counter <= COUNTER_RST;
      r_q.compare_reg_a        <= COMPARE_RST;
      r_q.compare_reg_b        <= COMPARE_RST;
      r_q.capture_reg_a        <= CAPTURE_RST;
      r_q.capture_reg_b        <= CAPTURE_RST;
      r_q.capture_reg_c        <= CAPTURE_RST;
      r_q.capture_reg_d        <= CAPTURE_RST;
      r_q.ready                <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout = r_q.ready;
  assign hresp     = r_q.err;
  assign hrdata    = r_q.rdata;
  assign cap_a_irq = r_q.irq[BIT_CAP_A];
  assign cap_b_irq = r_q.irq[BIT_CAP_B];
  assign cap_c_irq = r_q.irq[BIT_CAP_C];
  assign cap_d_irq = r_q.irq[BIT_CAP_D];
  assign cmp_a_irq = r_q.irq[BIT_CMP_A];
  assign cmp_b_irq = r_q.irq[BIT_CMP_B];
  assign wrap_irq  = r_q.irq[BIT_WRAP];

endmodule : tmx_timer_events

`default_nettype wire

// [testbench/tb_top.sv]
/*
  Self-checking bench of the timer event block: registers over AHB-Lite,
  compare, wrap and capture flags, buffering, low power and requests.
  Assumes the package offsets and a 100 MHz hclk.
*/
`default_nettype none

module tb_top
  import tmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        hready;
  logic        hreadyout;
  logic        low_power_entry = 1'b0;
  logic        ack = 1'b0;
  logic        ext_pin = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [3:0]  capture_pin = 4'hf;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [31:0] e;
  wire  [6:0]  irq_v;
  logic [6:0]  seen_q;
  logic [7:0]  ens [4] = '{8'h0c, 8'h02, 8'h0a, 8'h00};
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  assign hready = hreadyout;

  tmx_timer_events i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp(), .hrdata, .capture_pin, .ext_count_pin(ext_pin), .low_power_entry,
    .cap_a_irq(irq_v[6]), .cap_b_irq(irq_v[5]), .cap_c_irq(irq_v[4]), .cap_d_irq(irq_v[3]),
    .cmp_a_irq(irq_v[2]), .cmp_b_irq(irq_v[1]), .wrap_irq(irq_v[0])
  );

  tmx_cpu_intc_model i_intc (.hclk, .hresetn, .irq(irq_v), .ack, .seen_q);

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    chk(r, x);
  endtask : rd

  // Falling edge then rising edge on one capture pin
  task automatic pulse(input int i);
    capture_pin[i] <= 1'b0;
    repeat (4) @(posedge hclk);
    capture_pin[i] <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask : pulse

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_IRQ_ENABLE, 32'h01);
    rd(OFS_EVENT_STATUS, 32'h00);
    wr(OFS_IRQ_ENABLE, 32'h0);
    rd(OFS_IRQ_ENABLE, 32'h01);
    wr(8'h3c, 32'hff);
    rd(8'h3c, 32'h0);
    $display("reset test done");
    wr(OFS_COMPARE_A, 32'h4);
    wr(OFS_COMPARE_B, 32'h8);
    wr(OFS_COUNTER, 32'hfff0);
    repeat (60) @(posedge hclk);
    wr(OFS_EVENT_STATUS, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h0e);
    wr(OFS_EVENT_STATUS, 32'hfe);
    rd(OFS_EVENT_STATUS, 32'h0e);
    foreach (ens[k]) begin
      wr(OFS_IRQ_ENABLE, {24'h0, ens[k]});
      chk({25'h0, irq_v}, {25'h0, ens[k][7:1] & 7'h07});
    end
    wr(OFS_EVENT_STATUS, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_EVENT_STATUS, 32'hff);
    rd(OFS_EVENT_STATUS, 32'h01);
    wr(OFS_COUNTER, 32'h0);
    repeat (40) @(posedge hclk);
    xfer(OFS_COUNTER, 1'b0, 32'h0);
    chk({31'h0, r[15:0] <= 16'h4}, 32'h1);
    $display("compare test done");
    wr(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'hf0);
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      e = (32'hf0 << (3 - i)) & 32'hf0;
      xfer(OFS_EVENT_STATUS, 1'b0, 32'h0);
      chk(r & 32'hf0, e);
      chk({25'h0, irq_v}, e >> 1);
      xfer(OFS_CAPTURE_A + 8'(4 * i), 1'b0, 32'h0);
      chk({31'h0, r[15:0] != 16'h0}, 32'h1);
    end
    chk({25'h0, seen_q}, 32'h78);
    $display("capture test done");
    xfer(OFS_EVENT_STATUS, 1'b0, 32'h0);
    wr(OFS_EVENT_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h0c);
    for (int j = 0; j < 2; j++) begin
      pulse(j);
      xfer(OFS_CAPTURE_A + 8'(4 * j), 1'b0, 32'h0);
      e = r;
      pulse(j);
      rd(OFS_CAPTURE_C + 8'(4 * j), e);
      pulse(j + 2);
      rd(OFS_CAPTURE_C + 8'(4 * j), e);
      xfer(OFS_EVENT_STATUS, 1'b0, 32'h0);
      chk(r & (32'h20 >> j), 32'h20 >> j);
    end
    $display("buffer test done");
    for (int s = 1; s < 3; s++) begin
      wr(OFS_CONTROL, 32'(s));
      wr(OFS_COUNTER, 32'h0);
      repeat (10 << (2 * s + 1)) @(posedge hclk);
      xfer(OFS_COUNTER, 1'b0, 32'h0);
      chk({31'h0, r[15:0] inside {16'h000a, 16'h000b}}, 32'h1);
    end
    wr(OFS_CONTROL, 32'h03);
    wr(OFS_COUNTER, 32'h0);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    xfer(OFS_COUNTER, 1'b0, 32'h0);
    chk(r, 32'h5);
    $display("clock test done");
    wr(OFS_IRQ_ENABLE, 32'hfe);
    low_power_entry <= 1'b1;
    @(posedge hclk);
    low_power_entry <= 1'b0;
    rd(OFS_EVENT_STATUS, 32'h0);
    rd(OFS_IRQ_ENABLE, 32'h01);
    rd(OFS_CONTROL, 32'h0);
    $display("low power test done");
    results();
  end
endmodule : tb_top

`default_nettype wire

// [testbench/tmx_cpu_intc_model.sv]
/*
  Interrupt controller model: records every request level it sees until
  the CPU side acknowledges.
  Assumes request levels are synchronous to hclk.
*/
`default_nettype none

module tmx_cpu_intc_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Requests and acknowledge
  input  wire logic [6:0] irq,
  input  wire logic       ack,
  output var  logic [6:0] seen_q
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 7'h0;
    end else if (ack) begin
      seen_q <= 7'h0;
    end else begin
      seen_q <= seen_q | irq;
    end
  end
endmodule : tmx_cpu_intc_model

`default_nettype wire

// [testbench/tmx_timer_events_assertions.sv]
/*
  Port checks of the timer event block: bus timing, read data, fixed bits
  and interrupt request levels.
  Assumes the one-wait-state AHB-Lite slave that the design describes.
*/
`default_nettype none

module tmx_timer_events_chk
  import tmx_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Power and requests
  input wire logic        low_power_entry,
  input wire logic        cap_a_irq,
  input wire logic        cap_b_irq,
  input wire logic        cap_c_irq,
  input wire logic        cap_d_irq,
  input wire logic        cmp_a_irq,
  input wire logic        cmp_b_irq,
  input wire logic        wrap_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       acc;
  logic       rd_q;
  logic       wr_q;
  logic [7:0] ofs_q;
  logic [6:0] irq_v;

  assign acc   = hsel && hready && htrans[1];
  assign irq_v = {cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq, cmp_a_irq, cmp_b_irq, wrap_irq};

  // Data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      ofs_q <= 8'h00;
    end else begin
      rd_q  <= acc && !hwrite;
      wr_q  <= acc && hwrite;
      ofs_q <= acc ? haddr[7:0] : ofs_q;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("wait state not one cycle");
  rdata_hold_a: assert property (!$past(rd_q) |-> $stable(hrdata))
    else $error("read data moved without a read");
  fixed_bit_a: assert property (
    $past(rd_q) && $past(ofs_q) == OFS_IRQ_ENABLE |-> hrdata[0] && hrdata[31:8] == 24'h0)
    else $error("enable read wrong fixed bits");
  upper_zero_a: assert property (
    $past(rd_q) && ($past(ofs_q) == OFS_EVENT_STATUS || $past(ofs_q) == OFS_CONTROL)
    |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  irq_flag_a: assert property (
    $past(rd_q) && ($past(ofs_q) == OFS_IRQ_ENABLE || $past(ofs_q) == OFS_EVENT_STATUS)
    |-> ($past(irq_v) & ~hrdata[7:1]) == 7'h0)
    else $error("request without flag and enable");
  irq_drop_a: assert property (
    (|($past(irq_v) & ~irq_v)) |-> $past(wr_q) || $past(low_power_entry))
    else $error("request dropped without a write");
  sleep_quiet_a: assert property (low_power_entry |=> irq_v == 7'h0)
    else $error("request left in low power");

endmodule : tmx_timer_events_chk

bind tmx_timer_events tmx_timer_events_chk i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .low_power_entry, .cap_a_irq, .cap_b_irq, .cap_c_irq, .cap_d_irq, .cmp_a_irq, .cmp_b_irq,
  .wrap_irq
);

`default_nettype wire
